//--- rtl/tecl_limit_pair.sv
// 16-bit limit held as two byte registers
// assumes byte write strobes from the same clock domain
`timescale 1ns/10ps

module tecl_limit_pair
	import tecl_pkg::*;
#(
	parameter logic [7:0] LSB_RST = HLIM_LSB_RST,
	parameter logic [7:0] MSB_RST = HLIM_MSB_RST,
	parameter logic [7:0] LSB_MASK = HLIM_LSB_MASK,
	parameter logic [7:0] MSB_MASK = HLIM_MSB_MASK
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_lsb,
	input wire logic wr_msb,
	input wire logic [7:0] wdata,
	output logic [15:0] limit
);

	logic [7:0] lsb_r;
	logic [7:0] msb_r;

	// reserved bits are masked on write so they always read zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lsb_r <= LSB_RST & LSB_MASK;
			msb_r <= MSB_RST & MSB_MASK;
		end
		else
		begin
			if (wr_lsb)
				lsb_r <= wdata & LSB_MASK;
			if (wr_msb)
				msb_r <= wdata & MSB_MASK;
		end
	end

	assign limit = {msb_r, lsb_r};

endmodule

//--- rtl/tecl_pkg.sv
// constants for the thermal event clear and interrupt configuration bank
// assumes an outside protocol engine presents byte-wide register accesses

package tecl_pkg;

	// register addresses on the internal byte port
	localparam logic [7:0] ADDR_ERR_CLR = 8'h14;
	localparam logic [7:0] ADDR_SENSOR_CFG = 8'h1A;
	localparam logic [7:0] ADDR_IRQ_CFG = 8'h1B;
	localparam logic [7:0] ADDR_HLIM_LSB = 8'h1C;
	localparam logic [7:0] ADDR_HLIM_MSB = 8'h1D;

	// error clear field positions
	localparam int ERR_BUSY_BIT = 7;
	localparam int ERR_BLK_BIT = 6;
	localparam int ERR_PROT_BIT = 5;
	localparam int ERR_PEC_BIT = 1;
	localparam int ERR_PAR_BIT = 0;

	// sensor config field position
	localparam int SENSOR_OFF_BIT = 0;

	// interrupt config field positions
	localparam int IRQ_CLR_ALL_BIT = 7;
	localparam int IRQ_GLOBAL_BIT = 4;
	localparam int IRQ_CRIT_LOW_BIT = 3;
	localparam int IRQ_CRIT_HIGH_BIT = 2;
	localparam int IRQ_LOW_BIT = 1;
	localparam int IRQ_HIGH_BIT = 0;

	// reset values
	localparam logic [7:0] ERR_CLR_RST = 8'h00;
	localparam logic [7:0] SENSOR_CFG_RST = 8'h00;
	localparam logic [7:0] IRQ_CFG_RST = 8'h00;
	localparam logic [7:0] HLIM_LSB_RST = 8'h70;
	localparam logic [7:0] HLIM_MSB_RST = 8'h03;

	// writable bits of the limit bytes; cleared bits are reserved
	localparam logic [7:0] HLIM_LSB_MASK = 8'hFF;
	localparam logic [7:0] HLIM_MSB_MASK = 8'hFF;

	// state of a command-driven change of the global enable
	typedef enum logic [1:0] {
		tecl_en_idle,
		tecl_en_wait_stop,
		tecl_en_wait_start
	} tecl_en_state_type;

endpackage

//--- rtl/tecl_regs.sv
// error clear, sensor disable, interrupt config and high limit registers
// assumes the protocol engine, status flags and bus events share clk;
// status flags are owned outside and cleared by the strobes given here
`timescale 1ns/10ps

module tecl_regs
	import tecl_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bus_reset,
	input wire logic bus_start,
	input wire logic bus_stop,
	input wire logic ccc_enec,
	input wire logic ccc_disec,
	input wire logic ccc_rstdaa,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] thermal_flags_in,
	input wire logic [4:0] error_flags_in,
	output logic event_pending_clear,
	output logic [3:0] thermal_clear,
	output logic [4:0] error_clear,
	output logic sensor_off,
	output logic sensor_restart,
	output logic [15:0] high_limit,
	output logic global_irq_enable,
	output logic ibi_request
);

	// the map reaches 0x1D, so fewer address bits cannot decode it
	if (ADDR_W < 5 || ADDR_W > 8)
	begin : g_addr_check
		$error("tecl_regs: ADDR_W must be 5 to 8");
	end

	// true when an access address selects a given register
	function automatic logic addr_is(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0] target
	);
		logic [7:0] full;
		full = 8'h00;
		full[ADDR_W-1:0] = addr;
		addr_is = (full == target);
	endfunction

	// the five error flag positions packed {busy,blk,prot,pec,par}
	function automatic logic [4:0] err_bits(input logic [7:0] b);
		err_bits = {b[ERR_BUSY_BIT], b[ERR_BLK_BIT], b[ERR_PROT_BIT],
			b[ERR_PEC_BIT], b[ERR_PAR_BIT]};
	endfunction

	// registered state and the next values that load it
	logic [7:0] reg_rdata_r;
	logic [7:0] reg_rdata_nxt;
	logic event_clr_r;
	logic [3:0] thermal_clr_r;
	logic [4:0] err_clr_r;
	logic [4:0] err_clr_nxt;
	logic sensor_off_r;
	logic sensor_restart_r;
	logic [3:0] irq_en_r;
	logic en_cmd_r;
	logic en_cmd_nxt;
	logic en_active_r;
	logic en_active_nxt;
	tecl_en_state_type en_state_r;
	tecl_en_state_type en_state_nxt;
	logic [8:0] suppress_r;
	logic [8:0] suppress_nxt;
	logic ibi_r;
	logic ibi_nxt;

	// address decode
	wire hit_err_clr = addr_is(reg_addr, ADDR_ERR_CLR);
	wire hit_sensor = addr_is(reg_addr, ADDR_SENSOR_CFG);
	wire hit_irq = addr_is(reg_addr, ADDR_IRQ_CFG);
	wire hit_lsb = addr_is(reg_addr, ADDR_HLIM_LSB);
	wire hit_msb = addr_is(reg_addr, ADDR_HLIM_MSB);

	// write strobes
	wire wr_err_clr = reg_wr && hit_err_clr;
	wire wr_sensor = reg_wr && hit_sensor;
	wire wr_irq = reg_wr && hit_irq;
	wire wr_lsb = reg_wr && hit_lsb;
	wire wr_msb = reg_wr && hit_msb;

	// a zero in the global clear bit is simply ignored
	wire clr_all_go = wr_irq && reg_wdata[IRQ_CLR_ALL_BIT];

	// per-flag error clears, widened by the global clear
	assign err_clr_nxt = (err_bits(reg_wdata) & {5{wr_err_clr}})
		| {5{clr_all_go}};

	// clear strobes last one cycle; the owner of each flag drops it then
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			err_clr_r <= ERR_CLR_RST[4:0];
			thermal_clr_r <= 4'h0;
			event_clr_r <= 1'b0;
		end
		else
		begin
			err_clr_r <= err_clr_nxt;
			thermal_clr_r <= {4{clr_all_go}};
			event_clr_r <= clr_all_go;
		end
	end

	// sensor disable bit and the restart marker on its 1 to 0 change
	wire sensor_off_nxt = wr_sensor ? reg_wdata[SENSOR_OFF_BIT]
		: sensor_off_r;
	wire sensor_wake = sensor_off_r && !sensor_off_nxt;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sensor_off_r <= SENSOR_CFG_RST[SENSOR_OFF_BIT];
			sensor_restart_r <= 1'b0;
		end
		else
		begin
			sensor_off_r <= sensor_off_nxt;
			sensor_restart_r <= sensor_wake;
		end
	end

	// per-source enables; bit 4 and bit 7 are not stored from writes
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			irq_en_r <= IRQ_CFG_RST[3:0];
		else if (wr_irq)
			irq_en_r <= reg_wdata[3:0];
	end

	// global enable as commanded; bus reset and reset-address force off
	always_comb
	begin
		en_cmd_nxt = en_cmd_r;
		if (bus_reset || ccc_rstdaa || ccc_disec)
			en_cmd_nxt = 1'b0;
		else if (ccc_enec)
			en_cmd_nxt = 1'b1;
	end

	wire en_changed = (en_cmd_nxt != en_cmd_r);

	// a new enable waits for a STOP and then the following START
	always_comb
	begin
		en_state_nxt = en_state_r;
		en_active_nxt = en_active_r;
		case (en_state_r)
			tecl_en_idle:
			begin
				if (en_changed)
					en_state_nxt = tecl_en_wait_stop;
			end
			tecl_en_wait_stop:
			begin
				if (bus_stop)
					en_state_nxt = tecl_en_wait_start;
			end
			tecl_en_wait_start:
			begin
				if (bus_start)
				begin
					en_active_nxt = en_cmd_r;
					en_state_nxt = en_changed ? tecl_en_wait_stop
						: tecl_en_idle;
				end
			end
			default:
				en_state_nxt = tecl_en_idle;
		endcase
		// bus reset reloads at once, the link is being restarted anyway
		if (bus_reset)
		begin
			en_active_nxt = 1'b0;
			en_state_nxt = tecl_en_idle;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			en_cmd_r <= IRQ_CFG_RST[IRQ_GLOBAL_BIT];
			en_active_r <= IRQ_CFG_RST[IRQ_GLOBAL_BIT];
			en_state_r <= tecl_en_idle;
		end
		else
		begin
			en_cmd_r <= en_cmd_nxt;
			en_active_r <= en_active_nxt;
			en_state_r <= en_state_nxt;
		end
	end

	// interrupt sources; thermal order {crit_low,crit_high,low,high}
	wire [4:0] err_src = error_flags_in & {5{en_active_r}};
	wire [3:0] th_src = thermal_flags_in & irq_en_r
		& {4{en_active_r}};
	wire [8:0] all_flags = {error_flags_in, thermal_flags_in};

	// flags standing at a global clear are muted until seen low, so
	// only an event that comes afterwards can raise a new request;
	// the set by a clear wins over the release by a low flag
	assign suppress_nxt = clr_all_go ? 9'h1FF
		: (suppress_r & all_flags);

	assign ibi_nxt = !bus_reset
		&& (|({err_src, th_src} & ~suppress_nxt));

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			suppress_r <= 9'h000;
			ibi_r <= 1'b0;
		end
		else
		begin
			suppress_r <= suppress_nxt;
			ibi_r <= ibi_nxt;
		end
	end

	// high limit storage
	tecl_limit_pair #(
		.LSB_RST(HLIM_LSB_RST),
		.MSB_RST(HLIM_MSB_RST),
		.LSB_MASK(HLIM_LSB_MASK),
		.MSB_MASK(HLIM_MSB_MASK)
	) u_high_limit (
		.clk(clk),
		.rst_n(rst_n),
		.wr_lsb(wr_lsb),
		.wr_msb(wr_msb),
		.wdata(reg_wdata),
		.limit(high_limit)
	);

	// read selection; self-clearing bits always read zero: the error clear
	// branch drives 8'h00 and interrupt config bit 7 stays at the zero default
	always_comb
	begin
		reg_rdata_nxt = 8'h00;
		if (hit_err_clr)
			reg_rdata_nxt = 8'h00;
		else if (hit_sensor)
			reg_rdata_nxt[SENSOR_OFF_BIT] = sensor_off_r;
		else if (hit_irq)
		begin
			reg_rdata_nxt[IRQ_GLOBAL_BIT] = en_cmd_r;
			reg_rdata_nxt[3:0] = irq_en_r;
		end
		else if (hit_lsb)
			reg_rdata_nxt = high_limit[7:0];
		else if (hit_msb)
			reg_rdata_nxt = high_limit[15:8];
	end

	// read data holds until the next read; unmapped reads give zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata_r <= 8'h00;
		else if (reg_rd)
			reg_rdata_r <= reg_rdata_nxt;
	end

	// outputs, each from a flip-flop
	assign reg_rdata = reg_rdata_r;
	assign event_pending_clear = event_clr_r;
	assign thermal_clear = thermal_clr_r;
	assign error_clear = err_clr_r;
	assign sensor_off = sensor_off_r;
	assign sensor_restart = sensor_restart_r;
	assign global_irq_enable = en_active_r;
	assign ibi_request = ibi_r;

endmodule

//--- tb/tb_top.sv
// self-checking bench for the register bank
// assumes one 125 MHz clock; flags come from the flag model
`timescale 1ns/10ps
module tb_top import tecl_pkg::*;;
	logic clk = 1'h0, rst_n = 1'h0, bus_reset = 1'h0;
	logic bus_start = 1'h0, bus_stop = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic ccc_enec = 1'h0, ccc_disec = 1'h0, ccc_rstdaa = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [3:0] th_set = 4'h0, thermal_flags_in, thermal_clear;
	logic [4:0] er_set = 5'h00, error_flags_in, error_clear;
	logic event_pending_clear, sensor_off, sensor_restart;
	logic global_irq_enable, ibi_request;
	logic [15:0] high_limit;
	logic [7:0] clr [5] = '{8'h80, 8'h40, 8'h20, 8'h02, 8'h01};
	int n_fail = 0, comparisons = 0;
	always #4 clk = ~clk;
	tecl_regs tecl_regs_inst (.*);
	tecl_flag_model tecl_flag_model_inst (.clk, .rst_n, .th_set, .er_set,
		.th_clr(thermal_clear), .er_clr(error_clear),
		.th(thermal_flags_in), .er(error_flags_in));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// all driving happens 1 ns after an edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_wr = 1'h0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd = 1'h1;
		reg_addr = a;
		tick(1);
		reg_rd = 1'h0;
		chk({8'h00, reg_rdata}, {8'h00, e});
		// let an edge pass so a following call does not re-raise the strobe
		tick(1);
	endtask
	// command, then STOP and START so the new enable takes hold
	task automatic cmd(input logic [2:0] c);
		{ccc_enec, ccc_disec, ccc_rstdaa} = c;
		tick(1);
		{ccc_enec, ccc_disec, ccc_rstdaa} = 3'h0;
		bus_stop = 1'h1;
		tick(1);
		bus_stop = 1'h0;
		bus_start = 1'h1;
		tick(1);
		bus_start = 1'h0;
		tick(2);
	endtask
	task automatic flag(input logic [3:0] t, input logic [4:0] e);
		th_set = t;
		er_set = e;
		tick(1);
		th_set = 4'h0;
		er_set = 5'h00;
		tick(2);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog, far beyond the fewer than two hundred cycles the tests need
	initial
	begin
		#50000;
		n_fail++;
		conclude;
	end
	initial
	begin
		tick(12);
		rst_n = 1'h1;
		chk(high_limit, 16'h0370);
		rd(ADDR_HLIM_LSB, 8'h70);
		rd(ADDR_HLIM_MSB, 8'h03);
		rd(ADDR_SENSOR_CFG, 8'h00);
		wr(8'h15, 8'hFF);
		rd(8'h15, 8'h00);
		wr(ADDR_HLIM_LSB, 8'hA5);
		wr(ADDR_HLIM_MSB, 8'h5A);
		chk(high_limit, 16'h5AA5);
		rd(ADDR_HLIM_MSB, 8'h5A);
		wr(ADDR_SENSOR_CFG, 8'h01);
		chk(sensor_off, 16'h1);
		wr(ADDR_SENSOR_CFG, 8'h00);
		chk(sensor_off, 16'h0);
		tick(20);
		wr(ADDR_IRQ_CFG, 8'h1F);
		rd(ADDR_IRQ_CFG, 8'h0F);
		cmd(3'h4);
		rd(ADDR_IRQ_CFG, 8'h1F);
		chk(global_irq_enable, 16'h1);
		flag(4'h0, 5'h1F);
		wr(ADDR_ERR_CLR, 8'h1C);
		chk(error_flags_in, 16'h1F);
		// each clear bit hits exactly its own logged error
		for (int k = 0; k < 5; k++)
		begin
			flag(4'h0, 5'h1F);
			chk(ibi_request, 16'h1);
			wr(ADDR_ERR_CLR, clr[k]);
			chk(error_flags_in, 5'h1F & ~(5'h10 >> k));
			rd(ADDR_ERR_CLR, 8'h00);
		end
		wr(ADDR_IRQ_CFG, 8'h80);
		chk(error_flags_in, 16'h0);
		// one thermal source at a time, gated by its own enable
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_IRQ_CFG, 8'h0F ^ (8'h01 << i));
			flag(4'h1 << i, 5'h00);
			chk(ibi_request, 16'h0);
			wr(ADDR_IRQ_CFG, 8'h01 << i);
			tick(1);
			chk(ibi_request, 16'h1);
			wr(ADDR_IRQ_CFG, 8'h80 | (8'h01 << i));
			chk(thermal_flags_in, 16'h0);
			chk(ibi_request, 16'h0);
		end
		// a flag still standing at the clear stays quiet
		th_set = 4'h1;
		tick(2);
		wr(ADDR_IRQ_CFG, 8'h81);
		tick(3);
		chk(ibi_request, 16'h0);
		th_set = 4'h0;
		wr(ADDR_IRQ_CFG, 8'h81);
		flag(4'h1, 5'h00);
		chk(ibi_request, 16'h1);
		wr(ADDR_IRQ_CFG, 8'h80);
		cmd(3'h2);
		chk(global_irq_enable, 16'h0);
		flag(4'h0, 5'h1F);
		chk(ibi_request, 16'h0);
		cmd(3'h4);
		tick(1);
		chk(ibi_request, 16'h1);
		cmd(3'h1);
		chk(global_irq_enable, 16'h0);
		cmd(3'h4);
		bus_reset = 1'h1;
		tick(1);
		bus_reset = 1'h0;
		chk(global_irq_enable, 16'h0);
		chk(ibi_request, 16'h0);
		conclude;
	end
endmodule

//--- tb/tecl_checker.sv
// checker for the register bank ports
// assumes one clock; bound into every tecl_regs
`timescale 1ns/10ps
module tecl_checker
	import tecl_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bus_reset,
	input wire logic bus_start,
	input wire logic reg_wr,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic event_pending_clear,
	input wire logic [3:0] thermal_clear,
	input wire logic [4:0] error_clear,
	input wire logic sensor_off,
	input wire logic sensor_restart,
	input wire logic [15:0] high_limit,
	input wire logic global_irq_enable,
	input wire logic ibi_request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// write decodes; a global clear is the only source of bulk strobes
	wire logic w_err = reg_wr && reg_addr == ADDR_ERR_CLR;
	wire logic w_all = reg_wr && reg_addr == ADDR_IRQ_CFG && reg_wdata[7];
	wire logic w_cfg = reg_wr && reg_addr == ADDR_SENSOR_CFG;
	wire logic w_lsb = reg_wr && reg_addr == ADDR_HLIM_LSB;
	property p_err_map;
		w_err |=> error_clear == {$past(reg_wdata[7:5]), $past(reg_wdata[1:0])};
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("error clear strobes wrong");
	property p_err_idle;
		!w_err && !w_all |=> error_clear == 5'h00;
	endproperty
	a_err_idle: assert property (p_err_idle)
		else $error("error clear strobe without write");
	property p_all_idle;
		!w_all |=> thermal_clear == 4'h0 && !event_pending_clear;
	endproperty
	a_all_idle: assert property (p_all_idle)
		else $error("bulk clear without command");
	property p_all;
		w_all |=> error_clear == 5'h1F && thermal_clear == 4'hF
			&& event_pending_clear && !ibi_request;
	endproperty
	a_all: assert property (p_all)
		else $error("global clear incomplete");
	property p_off;
		w_cfg |=> sensor_off == $past(reg_wdata[0]);
	endproperty
	a_off: assert property (p_off)
		else $error("sensor off not updated");
	// restart marker pulses once, only after an on-again write
	property p_restart;
		sensor_restart == $past(w_cfg && sensor_off && !reg_wdata[0]);
	endproperty
	a_restart: assert property (p_restart)
		else $error("sensor restart marker wrong");
	property p_lim;
		w_lsb |=> high_limit[7:0] == $past(reg_wdata);
	endproperty
	a_lim: assert property (p_lim)
		else $error("limit low byte not updated");
	// enable may only move after a start, a bus reset or reset
	property p_gie;
		$changed(global_irq_enable) |->
			$past(bus_start) || $past(bus_reset) || !$past(rst_n);
	endproperty
	a_gie: assert property (p_gie)
		else $error("global enable moved without start");
	property p_brst;
		bus_reset |=> !global_irq_enable && !ibi_request;
	endproperty
	a_brst: assert property (p_brst)
		else $error("bus reset left enable on");
	property p_gate;
		!global_irq_enable [*2] |-> !ibi_request;
	endproperty
	a_gate: assert property (p_gate)
		else $error("interrupt while globally disabled");
	c_all: cover property (w_all);
	c_ibi: cover property ($rose(ibi_request));
	c_gie: cover property ($rose(global_irq_enable));
	c_restart: cover property (sensor_restart);
endmodule
bind tecl_regs tecl_checker #(.ADDR_W(ADDR_W)) tecl_checker_inst (.*);

//--- tb/tecl_flag_model.sv
// status flag owner beside the register bank
// assumes clears arrive as one-cycle pulses on clk
`timescale 1ns/10ps
module tecl_flag_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] th_set,
	input wire logic [4:0] er_set,
	input wire logic [3:0] th_clr,
	input wire logic [4:0] er_clr,
	output logic [3:0] th,
	output logic [4:0] er
);
	// a standing set beats a clear, so a live condition stays logged
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			th <= 4'h0;
			er <= 5'h00;
		end
		else
		begin
			th <= (th & ~th_clr) | th_set;
			er <= (er & ~er_clr) | er_set;
		end
	end
endmodule
